// file: spc_pkg.sv
// Shared constants, field layouts and state codes of the SPI port configuration block.
// Assumes a single 200 MHz clock domain; register addresses are 16-bit even byte addresses.
package spc_pkg;

  // Register map, twelve 16-bit registers at even addresses.
  localparam logic [15:0] ADDR_SETUP        = 16'hc0c8;
  localparam logic [15:0] ADDR_COMMAND      = 16'hc0ca;
  localparam logic [15:0] ADDR_EVENT_MASK   = 16'hc0cc;
  localparam logic [15:0] ADDR_EVENT_STATE  = 16'hc0ce;
  localparam logic [15:0] ADDR_EVENT_ACK    = 16'hc0d0;
  localparam logic [15:0] ADDR_CHECK_SETUP  = 16'hc0d2;
  localparam logic [15:0] ADDR_CHECK_RESULT = 16'hc0d4;
  localparam logic [15:0] ADDR_BYTE_WINDOW  = 16'hc0d6;
  localparam logic [15:0] ADDR_SEND_PTR     = 16'hc0d8;
  localparam logic [15:0] ADDR_SEND_LEN     = 16'hc0da;
  localparam logic [15:0] ADDR_RECV_PTR     = 16'hc0dc;
  localparam logic [15:0] ADDR_RECV_LEN     = 16'hc0de;

  // Configuration register layout.
  typedef struct packed {
    logic       shared_data_line_mode;
    logic       phase_adv;
    logic       sck_pos;
    logic [3:0] scale;
    logic       rsvd;
    logic       busy;
    logic       master;
    logic       ss_en;
    logic [4:0] ss_delay;
  } spc_setup_s;

  // Control register layout.
  typedef struct packed {
    logic       sck_strobe;
    logic       fifo_init;
    logic       byte_mode;
    logic       full_duplex;
    logic       ss_manual;
    logic       read_en;
    logic       tx_ready;
    logic       rx_ready;
    logic       tx_empty;
    logic       rx_full;
    logic [2:0] tx_len;
    logic [2:0] rx_len;
  } spc_command_s;

  // Values after reset.
  localparam logic [15:0] SETUP_RST    = 16'h801f;
  localparam logic [15:0] COMMAND_RST  = 16'h0000;
  localparam logic        RX_READY_RST = 1'b1;
  localparam logic [15:0] WORD_RST     = 16'h0000;

  // Event status bit positions.
  localparam int EV_XFR  = 0;
  localparam int EV_TX   = 1;
  localparam int EV_RX   = 2;
  localparam int EV_FERR = 7;
  localparam logic [15:0] EV_IMPL = 16'h0087;

  // Clock rates: the divider ratios are relative to the 48 MHz core rate.
  localparam int CLK_KHZ  = 200000;
  localparam int CORE_KHZ = 48000;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Master sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_TRAIL = 3'b011,
    ST_GAP   = 3'b100
  } spc_state_e;

  // Division ratio of the core rate for each scale code.
  function automatic int spc_ratio(input logic [3:0] scale);
    case (scale)
      4'h0: spc_ratio = 4;
      4'h1: spc_ratio = 6;
      4'h2: spc_ratio = 8;
      4'h3: spc_ratio = 12;
      4'h4: spc_ratio = 16;
      4'h5: spc_ratio = 24;
      4'h6: spc_ratio = 32;
      4'h7: spc_ratio = 48;
      4'h8: spc_ratio = 64;
      4'h9: spc_ratio = 96;
      4'ha, 4'hc, 4'he: spc_ratio = 128;
      default: spc_ratio = 192;
    endcase
  endfunction : spc_ratio

  // Half bit time in local clock cycles, rounded down, never below one.
  function automatic logic [15:0] spc_half_cycles(input logic [3:0] scale);
    int c;
    c = (spc_ratio(scale) * CLK_KHZ) / (2 * CORE_KHZ);
    if (c < 1) begin
      c = 1;
    end
    spc_half_cycles = c[15:0];
  endfunction : spc_half_cycles

  // Bit length field: zero means a full byte.
  function automatic logic [3:0] spc_bits(input logic [2:0] len);
    spc_bits = (len == 3'h0) ? BYTE_BITS : {1'b0, len};
  endfunction : spc_bits

endpackage : spc_pkg

// file: spc_sck_gen.sv
// Half bit time tick generator for the master serial clock.
// Assumes the caller holds run high for the whole sequence and keeps half stable meanwhile.
`timescale 1ns/1ps
`default_nettype none
module spc_sck_gen (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Control.
  input  wire logic        run,
  input  wire logic [15:0] half,
  // One-cycle pulse at every half bit time.
  output logic             tick
);

  logic [15:0] count;

  // Counting restarts whenever run drops so the first tick is a full half bit away.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (ce) begin
      if (!run || count >= half - 16'h0001) begin
        count <= 16'h0000;
        tick  <= run;
      end else begin
        count <= count + 16'h0001;
        tick  <= 1'b0;
      end
    end
  end

endmodule : spc_sck_gen
`default_nettype wire

// file: spc_port.sv
// SPI port with its configuration, control and status registers, master sequencer and slave shifter.
// Assumes one 200 MHz clock; pin inputs are asynchronous and are synchronised here.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module spc_port (
  // Clock, reset and clock enable.
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Register port.
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Serial clock pin.
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_n,
  // Master-out data pin, also the shared line.
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_n,
  // Master-in data pin.
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_n,
  // Slave select pin, active low.
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_oe_n
);

  spc_pkg::spc_setup_s   setup;
  spc_pkg::spc_command_s cmd;
  spc_pkg::spc_state_e   state;
  logic [15:0] ev_mask, ev_flags, chk_setup, chk_result;
  logic [15:0] send_ptr, send_len, recv_ptr, recv_len;
  logic [7:0]  tx_byte, rx_byte, shreg;
  logic        tx_pending, rx_ready, read_pend;
  logic        strobe_run, wphase, rphase;
  logic [4:0]  dcount;
  logic [4:0]  edges;
  logic        sck_lvl, tick;
  logic [3:0]  sync1, sync2, sync3;
  logic        done_pulse, wr_data, rd_data;
  logic        rx_done;
  logic [7:0]  rx_val;
  logic        load_tx;
  logic        start_ok;
  logic [15:0] ack_bits;
  logic [15:0] set_bits;
  logic        fifo_clr;
  logic [3:0]  s_bits;
  logic [7:0]  s_shreg;

  // Pin synchronisers; only sync2 and later stages feed logic.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      sync3 <= 4'hf;
    end else if (ce) begin
      sync1 <= {sck_i, mosi_i, miso_i, ss_n_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire s_sck    = sync2[3];
  wire s_sck_d  = sync3[3];
  wire s_mosi   = sync2[2];
  wire s_miso   = sync2[1];
  wire s_ss_n   = sync2[0];
  wire busy     = (state != spc_pkg::ST_IDLE);
  wire idle_lvl = ~setup.sck_pos; // Positive polarity idles low.
  wire s_lead   = (s_sck != s_sck_d) && (s_sck_d == idle_lvl);
  wire s_trail  = (s_sck != s_sck_d) && (s_sck_d != idle_lvl);
  wire auto_ss  = (setup.ss_delay != 5'h00);
  wire sel_hit  = wr && (addr == spc_pkg::ADDR_SETUP);
  assign wr_data = wr && (addr == spc_pkg::ADDR_BYTE_WINDOW);
  assign rd_data = rd && (addr == spc_pkg::ADDR_BYTE_WINDOW);

  // Configuration register; busy flag is live, the reserved bit stays zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setup <= spc_pkg::spc_setup_s'(spc_pkg::SETUP_RST);
    end else if (ce) begin
      setup.busy <= busy;
      setup.rsvd <= 1'b0;
      if (sel_hit) begin
        setup.shared_data_line_mode <= wdata[15];
        setup.phase_adv             <= wdata[14];
        setup.sck_pos               <= wdata[13];
        setup.scale                 <= wdata[12:9];
        setup.ss_en                 <= wdata[5];
        setup.ss_delay              <= wdata[4:0];
        // Changing role mid-transfer would strand the pins, so a role write while busy is dropped and the old role stays.
        if (!setup.busy) begin
          setup.master <= wdata[6];
        end
      end
    end
  end

  // Control register writable fields; strobe bits act once and never store.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= spc_pkg::spc_command_s'(spc_pkg::COMMAND_RST);
    end else if (ce) begin
      if (wr && addr == spc_pkg::ADDR_COMMAND) begin
        cmd.byte_mode <= wdata[13];
        cmd.ss_manual <= wdata[11];
        cmd.tx_len    <= wdata[5:3];
        cmd.rx_len    <= wdata[2:0];
        cmd.full_duplex <= wdata[12] && !setup.shared_data_line_mode;
      end else if (setup.shared_data_line_mode) begin
        cmd.full_duplex <= 1'b0;
      end
    end
  end

  // Read-phase request is sticky in master mode until the sequence starts.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_pend <= 1'b0;
    end else if (ce) begin
      if (wr && addr == spc_pkg::ADDR_COMMAND) begin
        read_pend <= wdata[10];
      end else if (setup.master && state == spc_pkg::ST_IDLE && start_ok) begin
        read_pend <= 1'b0;
      end
    end
  end

  // Plain storage registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev_mask    <= spc_pkg::WORD_RST;
      chk_setup  <= spc_pkg::WORD_RST;
      chk_result <= spc_pkg::WORD_RST;
      send_ptr   <= spc_pkg::WORD_RST;
      send_len   <= spc_pkg::WORD_RST;
      recv_ptr   <= spc_pkg::WORD_RST;
      recv_len   <= spc_pkg::WORD_RST;
    end else if (ce && wr) begin
      unique case (addr)
        spc_pkg::ADDR_EVENT_MASK:   ev_mask    <= wdata & spc_pkg::EV_IMPL & 16'h0007;
        spc_pkg::ADDR_CHECK_SETUP:  chk_setup  <= wdata;
        spc_pkg::ADDR_CHECK_RESULT: chk_result <= wdata;
        spc_pkg::ADDR_SEND_PTR:     send_ptr   <= wdata;
        spc_pkg::ADDR_SEND_LEN:     send_len   <= wdata;
        spc_pkg::ADDR_RECV_PTR:     recv_ptr   <= wdata;
        spc_pkg::ADDR_RECV_LEN:     recv_len   <= wdata;
        default: ;
      endcase
    end
  end

  // Transmit holding byte; a write while one waits is a FIFO error.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_byte    <= 8'h00;
      tx_pending <= 1'b0;
    end else if (ce) begin
      if (wr && addr == spc_pkg::ADDR_COMMAND && wdata[14]) begin
        tx_pending <= 1'b0;
      end else if (wr_data && !tx_pending) begin
        tx_byte    <= wdata[7:0];
        tx_pending <= 1'b1;
      end else if (load_tx) begin
        tx_pending <= 1'b0;
      end
    end
  end

  // Receive data flag: set by completion, cleared by reading the data register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_ready <= spc_pkg::RX_READY_RST;
      rx_byte  <= 8'h00;
    end else if (ce) begin
      if (rx_done) begin
        rx_ready <= 1'b1; // Completion wins over a read in the same cycle.
        rx_byte  <= rx_val;
      end else if (rd_data) begin
        rx_ready <= 1'b0;
      end
    end
  end

  // Sticky event flags; hardware set wins over software acknowledge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev_flags <= spc_pkg::WORD_RST;
    end else if (ce) begin
      ev_flags <= (ev_flags & ~(ack_bits)) | set_bits;
    end
  end

  // Event sources and software acknowledge, acknowledge limited to the implemented low bits.
  assign ack_bits = (wr && addr == spc_pkg::ADDR_EVENT_ACK) ? (wdata & 16'h0007) : 16'h0000;
  assign fifo_clr = wr && addr == spc_pkg::ADDR_COMMAND && wdata[14];
  assign set_bits = {8'h00, wr_data && tx_pending, 4'h0,
                     rx_done && cmd.byte_mode, load_tx && cmd.byte_mode,
                     done_pulse && !cmd.byte_mode};

  // FIFO init does not clear the FIFO error bit; fifo_clr feeds nothing.
  wire unused_clr = fifo_clr;

  // Master tick generator runs whenever the sequencer is away from idle.
  spc_sck_gen u_gen (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .run  (busy),
    .half (spc_pkg::spc_half_cycles(setup.scale)),
    .tick (tick)
  );

  assign start_ok = setup.master && (tx_pending || read_pend || (wr && addr == spc_pkg::ADDR_COMMAND && wdata[15]));
  assign load_tx  = setup.master && state == spc_pkg::ST_IDLE && start_ok && tx_pending && !read_pend
                    || setup.master && state == spc_pkg::ST_IDLE && start_ok && tx_pending && cmd.full_duplex;
  wire [3:0] m_bits = rphase && !wphase ? spc_pkg::spc_bits(cmd.rx_len) : spc_pkg::spc_bits(cmd.tx_len);
  wire m_in = setup.shared_data_line_mode ? s_mosi : s_miso;

  // Master sequencer: lead delay, shifting edges, trail delay, select high gap.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= spc_pkg::ST_IDLE;
      dcount     <= 5'h00;
      edges      <= 5'h00;
      sck_lvl    <= 1'b0;
      shreg      <= 8'h00;
      wphase     <= 1'b0;
      rphase     <= 1'b0;
      strobe_run <= 1'b0;
      done_pulse <= 1'b0;
    end else if (ce) begin
      done_pulse <= 1'b0;
      unique case (state)
        spc_pkg::ST_IDLE: begin
          sck_lvl <= idle_lvl;
          if (start_ok) begin
            strobe_run <= !tx_pending && !read_pend;
            wphase     <= tx_pending && (!read_pend || cmd.full_duplex);
            rphase     <= read_pend || (tx_pending && cmd.full_duplex);
            shreg      <= tx_byte;
            edges      <= 5'h00;
            dcount     <= setup.ss_delay;
            state      <= auto_ss ? spc_pkg::ST_LEAD : spc_pkg::ST_SHIFT;
          end
        end
        spc_pkg::ST_LEAD: begin
          if (tick) begin
            dcount <= dcount - 5'h01;
            if (dcount == 5'h01) begin
              state <= spc_pkg::ST_SHIFT;
            end
          end
        end
        spc_pkg::ST_SHIFT: begin
          if (tick) begin
            sck_lvl <= ~sck_lvl;
            edges   <= edges + 5'h01;
            // Advanced phase samples on the leading edge; delayed samples on the trailing edge.
            if (edges[0] != setup.phase_adv) begin
              shreg <= {shreg[6:0], m_in};
            end
            // Two edges a bit; the last one lands on edge number twice the bit count.
            if (edges == {m_bits, 1'b0} - 5'h01) begin
              done_pulse <= 1'b1;
              dcount     <= setup.ss_delay;
              state      <= auto_ss ? spc_pkg::ST_TRAIL : spc_pkg::ST_IDLE;
            end
          end
        end
        spc_pkg::ST_TRAIL: begin
          if (tick) begin
            dcount <= dcount - 5'h01;
            if (dcount == 5'h01) begin
              dcount <= setup.ss_delay;
              state  <= spc_pkg::ST_GAP;
            end
          end
        end
        spc_pkg::ST_GAP: begin
          if (tick) begin
            dcount <= dcount - 5'h01;
            if (dcount == 5'h01) begin
              state <= spc_pkg::ST_IDLE;
            end
          end
        end
        default: state <= spc_pkg::ST_IDLE;
      endcase
    end
  end

  // Slave shifter; it samples and shifts out on the leading edge and does nothing on the trailing one.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_bits  <= 4'h0;
      s_shreg <= 8'h00;
    end else if (ce) begin
      if (setup.master || s_ss_n) begin
        s_bits  <= 4'h0;
        s_shreg <= tx_byte;
      end else if (s_lead) begin
        s_shreg <= {s_shreg[6:0], s_mosi};
        s_bits  <= (s_bits + 4'h1 == spc_pkg::spc_bits(cmd.rx_len)) ? 4'h0 : s_bits + 4'h1;
      end
    end
  end

  assign rx_done = setup.master ? (done_pulse && rphase && !strobe_run)
                                : (!s_ss_n && s_lead && s_bits + 4'h1 == spc_pkg::spc_bits(cmd.rx_len));
  assign rx_val  = setup.master ? shreg : {s_shreg[6:0], s_mosi};

  // Pin drivers, all registered.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_o     <= 1'b0;
      sck_oe_n  <= 1'b1;
      mosi_o    <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_o    <= 1'b0;
      miso_oe_n <= 1'b1;
      ss_n_o    <= 1'b1;
      ss_oe_n   <= 1'b1;
    end else if (ce) begin
      sck_o     <= sck_lvl;
      sck_oe_n  <= !setup.master;
      // Shifting out the top bit: delayed phase moves data on the trailing edge.
      mosi_o    <= setup.master ? shreg[7] : s_shreg[7];
      mosi_oe_n <= setup.master ? !(wphase && busy) || strobe_run
                                : !(setup.shared_data_line_mode && !cmd.read_en && !s_ss_n);
      miso_o    <= s_shreg[7];
      miso_oe_n <= setup.master || setup.shared_data_line_mode || s_ss_n;
      ss_n_o    <= auto_ss ? !(state == spc_pkg::ST_LEAD || state == spc_pkg::ST_SHIFT
                               || state == spc_pkg::ST_TRAIL) : !cmd.ss_manual;
      ss_oe_n   <= !(setup.master && setup.ss_en);
    end
  end

  // Read data stands in the cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd) begin
        unique case (addr)
          spc_pkg::ADDR_SETUP:        rdata <= setup;
          spc_pkg::ADDR_COMMAND:      rdata <= {2'b00, cmd.byte_mode, cmd.full_duplex, cmd.ss_manual, read_pend,
                                                !tx_pending, rx_ready, !tx_pending, rx_ready,
                                                cmd.tx_len, cmd.rx_len};
          spc_pkg::ADDR_EVENT_MASK:   rdata <= ev_mask;
          spc_pkg::ADDR_EVENT_STATE:  rdata <= ev_flags;
          spc_pkg::ADDR_CHECK_SETUP:  rdata <= chk_setup;
          spc_pkg::ADDR_CHECK_RESULT: rdata <= chk_result;
          spc_pkg::ADDR_BYTE_WINDOW:  rdata <= {8'h00, rx_byte};
          spc_pkg::ADDR_SEND_PTR:     rdata <= send_ptr;
          spc_pkg::ADDR_SEND_LEN:     rdata <= send_len;
          spc_pkg::ADDR_RECV_PTR:     rdata <= recv_ptr;
          spc_pkg::ADDR_RECV_LEN:     rdata <= recv_len;
          default:                    rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : spc_port
`default_nettype wire

// file: spc_port_chk.sv
// Concurrent checks on the register port and master pins of the SPI port.
// Assumes ce is held high by the bench and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module spc_port_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  // Register port.
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Master pins.
  input wire logic        sck_o,
  input wire logic        ss_n_o,
  input wire logic        ss_oe_n
);
  logic       sh15;
  logic       sh13;
  logic       sh5;
  logic [4:0] dly;

  // Shadow of the shared-line, polarity, select-enable and delay setup fields; the role bit is left out because busy can refuse it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sh15, sh13, sh5, dly} <= {3'h4, 5'h1f};
    end else if (ce && wr && addr == spc_pkg::ADDR_SETUP) begin
      {sh15, sh13, sh5, dly} <= {wdata[15], wdata[13], wdata[5], wdata[4:0]};
    end
  end

  // All checks share one clock and its reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property ($past(rd) && ($past(addr) < 16'hc0c8 || $past(addr) > 16'hc0de
    || $past(addr[0])) |-> rdata == 16'h0000) else $error("unmapped read not zero");
  a_rsvd_zero: assert property ($past(rd) && $past(addr) == spc_pkg::ADDR_SETUP |-> !rdata[8])
    else $error("reserved setup bit set");
  a_duplex_refused: assert property ($past(rd) && $past(addr) == spc_pkg::ADDR_COMMAND && sh15
    |-> !rdata[12]) else $error("full duplex with shared line");
  a_select_enable: assert property (!ss_oe_n |-> sh5 || $past(sh5))
    else $error("select driven while disabled");
  a_idle_polarity: assert property ($fell(ss_n_o) |-> sck_o == !sh13)
    else $error("clock not idle at select");
  a_lead_delay: assert property ($fell(ss_n_o) |-> $stable(sck_o) [*7])
    else $error("clock moved inside lead delay");
  a_gap_time: assert property ($rose(ss_n_o) && dly != 5'h00 |-> ##1 ss_n_o [*7])
    else $error("select high time too short");
  a_busy_flag: assert property ($past(rd) && $past(addr) == spc_pkg::ADDR_SETUP && !$past(ss_n_o)
    && !$past(ss_n_o, 2) && dly != 5'h00 |-> rdata[7]) else $error("busy clear during frame");

  c_frame: cover property ($fell(ss_n_o));
  c_busy: cover property ($past(rd) && rdata[7]);
  c_unmapped: cover property ($past(rd) && $past(addr) == 16'hc0e0);
endmodule : spc_port_chk
bind spc_port spc_port_chk chk_u (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .sck_o(sck_o), .ss_n_o(ss_n_o), .ss_oe_n(ss_oe_n));
`default_nettype wire

// file: spc_slave_model.sv
// Behavioural SPI slave standing on the master pins.
// Assumes the master holds its clock idle outside frames.
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
  // Pins seen from the slave.
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       pol,
  // Reply byte and captured byte.
  input  wire logic [7:0] reply,
  output logic            sdo,
  output logic [7:0]      got
);
  logic [7:0] sh = 8'h00;
  logic       mosi_d = 1'b0;

  // The master moves data in the same step as its clock edge, so sample a copy that lags by 1 ns.
  always @(mosi) begin
    mosi_d <= #1 mosi;
  end

  // Load the reply on select so the first bit waits for the first leading edge.
  always @(negedge ss_n) begin
    sh = reply;
    sdo = reply[7];
    got = 8'h00;
  end

  // Sample on the leading edge, shift on the trailing edge, MSB first.
  always @(sck) begin
    if (!ss_n && sck == pol) begin
      got = {got[6:0], mosi_d};
    end else if (!ss_n) begin
      sh = {sh[6:0], 1'b0};
      sdo = sh[7];
    end
  end

  // A released line shows the inverse of its last bit, so a stale value cannot pass.
  always @(posedge ss_n) begin
    sdo = ~sdo;
  end
endmodule : spc_slave_model
`default_nettype wire

// file: spi_port_configuration_tb_top.sv
// Self-checking bench: register table, master transfers at every scale, select and shared line.
// Assumes the checker is bound to the port and the slave model sits on the master pins.
`timescale 1ns/1ps
`default_nettype none
module spi_port_configuration_tb_top;
  typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [15:0] e;} spc_row_s;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_n_o, ss_oe_n;
  wire         sck_i, mosi_i, miso_i, ss_n_i, sdo;
  logic [7:0]  got;
  logic [7:0]  reply = 8'h3c;
  logic        sck_q = 1'b0;
  int          bad_count = 0, n_checks = 0, cyc = 0, cnt = 0, hp = 0, drv = 0, half;
  int          ratio [16] = '{4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 128, 192, 128, 192};
  spc_row_s    rows [10] = '{
    '{1'b0, spc_pkg::ADDR_SETUP, 16'h0000, 16'h801f}, '{1'b0, spc_pkg::ADDR_COMMAND, 16'h0000, 16'h03c0},
    '{1'b1, spc_pkg::ADDR_COMMAND, 16'h1000, 16'h03c0}, '{1'b1, spc_pkg::ADDR_SETUP, 16'h7fff, 16'h7e7f},
    '{1'b1, spc_pkg::ADDR_COMMAND, 16'h1000, 16'h13c0}, '{1'b1, spc_pkg::ADDR_EVENT_MASK, 16'hffff, 16'h0007},
    '{1'b1, spc_pkg::ADDR_EVENT_STATE, 16'hffff, 16'h0000}, '{1'b1, spc_pkg::ADDR_CHECK_RESULT, 16'ha5c3, 16'ha5c3},
    '{1'b1, spc_pkg::ADDR_RECV_LEN, 16'h1234, 16'h1234}, '{1'b1, 16'hc0e0, 16'hffff, 16'h0000}};

  always #2.5 clk = ~clk;

  // Wire levels: the select line pulls high, a released clock sits low.
  assign sck_i = sck_oe_n ? 1'b0 : sck_o;
  assign ss_n_i = ss_oe_n ? 1'b1 : ss_n_o;
  assign miso_i = miso_oe_n ? sdo : miso_o;
  assign mosi_i = mosi_oe_n ? sdo : mosi_o;

  spc_port dut_u (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
    .miso_i(miso_i), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n_i), .ss_n_o(ss_n_o), .ss_oe_n(ss_oe_n));
  spc_slave_model model_u (.sck(sck_o), .ss_n(ss_n_o), .mosi(mosi_i), .pol(1'b1), .reply(reply), .sdo(sdo),
    .got(got));

  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    if (n != "") chk_word(n, e, v);
  endtask : rd_chk

  // Poll the busy bit under a bound long enough for the slowest scale.
  task automatic wait_idle();
    v = 16'hffff;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 5000 && v[7] !== 1'b0; k++) rd_chk(spc_pkg::ADDR_SETUP, 16'h0000, "");
  endtask : wait_idle

  // Half bit time seen on the clock pin within a frame, master drive of the shared line, and the hang limit.
  always @(posedge clk) begin
    cyc++;
    cnt = ss_n_o ? 0 : cnt + 1;
    if (sck_o !== sck_q && !ss_n_o) begin
      hp = cnt;
      cnt = 0;
    end
    sck_q = sck_o;
    if (!ss_n_o && !mosi_oe_n) drv++;
    if (cyc == 90000) begin
      bad_count++;
      stop_test();
    end
  end

  // Table rows, transfers at every scale code, then select and shared-line cases.
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e, "register");
    end
    for (int i = 0; i < 16; i++) begin
      half = ratio[i] * 200 / 96;
      wr_reg(spc_pkg::ADDR_SETUP, {3'h3, i[3:0], 9'h061});
      wr_reg(spc_pkg::ADDR_COMMAND, 16'h3000);
      wr_reg(spc_pkg::ADDR_BYTE_WINDOW, 16'h00a5);
      if (i == 0) begin
        repeat (3) @(posedge clk);
        rd_chk(spc_pkg::ADDR_SETUP, 16'h60e1, "busy");
        wr_reg(spc_pkg::ADDR_SETUP, 16'h6021);
      end
      wait_idle();
      rd_chk(spc_pkg::ADDR_SETUP, {3'h3, i[3:0], 9'h061}, "setup");
      chk_word("sent", 16'h00a5, {8'h00, got});
      rd_chk(spc_pkg::ADDR_BYTE_WINDOW, 16'h003c, "received");
      chk_word("half bit", half[15:0], hp[15:0]);
    end
    wr_reg(spc_pkg::ADDR_SETUP, 16'h6060);
    wr_reg(spc_pkg::ADDR_COMMAND, 16'h0800);
    repeat (3) @(posedge clk);
    chk_bit("select", 1'b0, ss_n_o);
    chk_bit("select enable", 1'b0, ss_oe_n);
    chk_bit("idle clock", 1'b0, sck_o);
    wr_reg(spc_pkg::ADDR_COMMAND, 16'h0000);
    wr_reg(spc_pkg::ADDR_SETUP, 16'h4040);
    repeat (3) @(posedge clk);
    chk_bit("select", 1'b1, ss_n_o);
    chk_bit("select enable", 1'b1, ss_oe_n);
    chk_bit("idle clock", 1'b1, sck_o);
    reply = 8'h96;
    wr_reg(spc_pkg::ADDR_SETUP, 16'he061);
    drv = 0;
    wr_reg(spc_pkg::ADDR_COMMAND, 16'h2400);
    wait_idle();
    chk_word("shared line drive", 16'h0000, drv[15:0]);
    rd_chk(spc_pkg::ADDR_BYTE_WINDOW, 16'h0096, "shared receive");
    stop_test();
  end
endmodule : spi_port_configuration_tb_top
`default_nettype wire
